// *** logic/aisrc_regs.svh ***
// register offsets, field positions and reset values of the interrupt source block
`ifndef AISRC_REGS_SVH
`define AISRC_REGS_SVH

// register byte offsets
`define AISRC_OFF_STATUS  12'h000
`define AISRC_OFF_ENABLE  12'h004
`define AISRC_OFF_CTRL    12'h008
`define AISRC_OFF_PENDING 12'h00c
`define AISRC_OFF_RAW     12'h010

// event bit positions, shared by status, enable and pending
`define AISRC_NUM_EVT       13
`define AISRC_BIT_ACQ_RUN   0
`define AISRC_BIT_ACQ_STOP  1
`define AISRC_BIT_ACQ_DONE  2
`define AISRC_BIT_IN_QTR    3
`define AISRC_BIT_PER_CONV  4
`define AISRC_BIT_EOSCAN    5
`define AISRC_BIT_EOINT     6
`define AISRC_BIT_OUT_RUN   7
`define AISRC_BIT_OUT_DONE  8
`define AISRC_BIT_OUT_QTR   9
`define AISRC_BIT_HICHAN    10
`define AISRC_BIT_WRAP      11
`define AISRC_BIT_EXT       12

// control register fields
`define AISRC_CTRL_MASTER_EN 0
`define AISRC_CTRL_EXT_RISE  1
`define AISRC_CTRL_W         2

// raw register fields
`define AISRC_RAW_ACQ_RUN  0
`define AISRC_RAW_OUT_RUN  1
`define AISRC_RAW_STOP_PIN 2
`define AISRC_RAW_EXT_PIN  3

// edge detector lanes
`define AISRC_LANE_IN_QTR  0
`define AISRC_LANE_OUT_QTR 1
`define AISRC_LANE_STOP    2
`define AISRC_LANE_EXT     3
`define AISRC_LANES        4

// pin synchroniser lanes
`define AISRC_PIN_STOP 0
`define AISRC_PIN_EXT  1
`define AISRC_PINS     2

// reset values
`define AISRC_RST_EVT  13'h0000
`define AISRC_RST_CTRL 2'h0
`define AISRC_RST_DATA 32'h0000_0000

`endif

// *** logic/aisrc_pkg.sv ***
// types shared by the interrupt source block
package aisrc_pkg;

	// event vector, one bit per source
	typedef logic [12:0] aisrc_evt_type;

	// signals from the input acquisition sequencer, same clock
	typedef struct packed {
		logic acq_running_event;
		logic acq_complete_event;
		logic input_buffer_quarter_level;
		logic per_conversion_event;
		logic multi_scan;
		logic end_of_scan_event;
		logic end_of_interval_event;
	} aisrc_acq_type;

	// signals from the output waveform engine, same clock
	typedef struct packed {
		logic out_running;
		logic out_complete;
		logic output_buffer_quarter_level;
		logic high_channel_update;
		logic retransmit_mode;
		logic wrap_end;
	} aisrc_out_type;

endpackage

// *** logic/aisrc_sync.sv ***
// three-stage pin synchroniser plus a filter flop that accepts a change once stages two and three agree
`include "aisrc_regs.svh"

module aisrc_sync #(
	parameter int WIDTH = `AISRC_PINS
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// asynchronous pins in, settled levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			// per-lane flops, so no variable is shared between processes
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic level_r;

			// stage one feeds stage two only, to keep metastability contained
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_r    <= 1'b0;
					s2_r    <= 1'b0;
					s3_r    <= 1'b0;
					level_r <= 1'b0;
				end else begin
					s1_r <= pin_in[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					// agreement filter drops single-cycle glitches
					if (s2_r == s3_r) begin
						level_r <= s3_r;
					end
				end
			end

			// settled level straight from the filter flop
			assign level_out[i] = level_r;
		end
	endgenerate

endmodule

// *** logic/aisrc_edge.sv ***
// per-lane rising and falling edge detector, one-cycle pulses out
module aisrc_edge #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// levels in, edge pulses out
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] prev_r;

	// previous level; starts low so a level high out of reset counts as a rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= level_in;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_edge
			assign rise[i] = level_in[i] & ~prev_r[i];
			assign fall[i] = ~level_in[i] & prev_r[i];
		end
	endgenerate

endmodule

// *** logic/aisrc_top.sv ***
// interrupt source collector for acquisition, waveform output and external pin
//
// The register offsets and register access over APB were left to the implementer.
`include "aisrc_regs.svh"

module aisrc_top (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic      [31:0]            prdata,
	// event sources on the same clock
	input  wire aisrc_pkg::aisrc_acq_type acq_in,
	input  wire aisrc_pkg::aisrc_out_type out_in,
	// asynchronous pins
	input  wire logic                   acq_stop_pin,
	input  wire logic                   ext_irq_pin,
	// request line toward the host
	output logic                        irq_n
);

	// registers
	aisrc_pkg::aisrc_evt_type status_r;
	aisrc_pkg::aisrc_evt_type status_nxt;
	aisrc_pkg::aisrc_evt_type enable_r;
	logic [`AISRC_CTRL_W-1:0] ctrl_r;

	// event path
	aisrc_pkg::aisrc_evt_type evt_set;
	logic [`AISRC_PINS-1:0]   pin_level;
	logic [`AISRC_LANES-1:0]  lane_level;
	logic [`AISRC_LANES-1:0]  lane_rise;
	logic [`AISRC_LANES-1:0]  lane_fall;
	logic                     ext_edge;

	// bus decode
	logic        setup_ph;
	logic        wr_take;
	logic [31:0] rd_word;
	logic        addr_ok;
	aisrc_pkg::aisrc_evt_type w1c_mask;

	// map an offset to a known register
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == `AISRC_OFF_STATUS) || (a == `AISRC_OFF_ENABLE) ||
			(a == `AISRC_OFF_CTRL) || (a == `AISRC_OFF_PENDING) ||
			(a == `AISRC_OFF_RAW);
	endfunction

	// true when a write to the given offset is taken this cycle
	function automatic logic wr_hit(input logic take, input logic [11:0] a,
			input logic [11:0] off);
		wr_hit = take && (a == off);
	endfunction

	// pins arrive from the connector, outside this clock
	aisrc_sync #(
		.WIDTH(`AISRC_PINS)
	) u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    ({ext_irq_pin, acq_stop_pin}),
		.level_out (pin_level)
	);

	// lanes whose transitions, not levels, are the events
	always_comb begin
		lane_level = '0;
		lane_level[`AISRC_LANE_IN_QTR]  = acq_in.input_buffer_quarter_level;
		lane_level[`AISRC_LANE_OUT_QTR] = out_in.output_buffer_quarter_level;
		lane_level[`AISRC_LANE_STOP]    = pin_level[`AISRC_PIN_STOP];
		lane_level[`AISRC_LANE_EXT]     = pin_level[`AISRC_PIN_EXT];
	end

	aisrc_edge #(
		.WIDTH(`AISRC_LANES)
	) u_edge (
		.pclk     (pclk),
		.presetn  (presetn),
		.level_in (lane_level),
		.rise     (lane_rise),
		.fall     (lane_fall)
	);

	// external pin edge chosen by software; flipping the choice
	// never fabricates an edge because only true transitions count
	assign ext_edge = ctrl_r[`AISRC_CTRL_EXT_RISE] ?
		lane_rise[`AISRC_LANE_EXT] : lane_fall[`AISRC_LANE_EXT];

	// event set vector; level sources keep setting while active
	always_comb begin
		evt_set = '0;
		evt_set[`AISRC_BIT_ACQ_RUN]  = acq_in.acq_running_event;
		evt_set[`AISRC_BIT_ACQ_STOP] = lane_rise[`AISRC_LANE_STOP];
		evt_set[`AISRC_BIT_ACQ_DONE] = acq_in.acq_complete_event;
		// reaching the quarter mark, not sitting above it
		evt_set[`AISRC_BIT_IN_QTR]   = lane_rise[`AISRC_LANE_IN_QTR];
		evt_set[`AISRC_BIT_PER_CONV] = acq_in.per_conversion_event;
		evt_set[`AISRC_BIT_EOSCAN]   = acq_in.multi_scan &
			acq_in.end_of_scan_event;
		evt_set[`AISRC_BIT_EOINT]    = acq_in.multi_scan &
			acq_in.end_of_interval_event;
		evt_set[`AISRC_BIT_OUT_RUN]  = out_in.out_running;
		evt_set[`AISRC_BIT_OUT_DONE] = out_in.out_complete;
		evt_set[`AISRC_BIT_OUT_QTR]  = lane_rise[`AISRC_LANE_OUT_QTR];
		evt_set[`AISRC_BIT_HICHAN]   = out_in.high_channel_update;
		evt_set[`AISRC_BIT_WRAP]     = out_in.retransmit_mode &
			out_in.wrap_end;
		evt_set[`AISRC_BIT_EXT]      = ext_edge;
	end

	// apb phases: pready is registered at setup, so the access phase has no wait cycle
	assign setup_ph = psel && !penable && !pready;
	assign wr_take  = psel && penable && pready && pwrite && !pslverr;
	assign addr_ok  = addr_known(paddr);

	// write-one-to-clear strobe for the status register
	assign w1c_mask = wr_hit(wr_take, paddr, `AISRC_OFF_STATUS) ?
		pwdata[`AISRC_NUM_EVT-1:0] : `AISRC_RST_EVT;

	// a set in the same cycle as its clear wins, so no event is lost
	assign status_nxt = (status_r & ~w1c_mask) | evt_set;

	// sticky flags, latched per source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= `AISRC_RST_EVT;
		end else begin
			status_r <= status_nxt;
		end
	end

	// per-source enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= `AISRC_RST_EVT;
		end else if (wr_hit(wr_take, paddr, `AISRC_OFF_ENABLE)) begin
			enable_r <= pwdata[`AISRC_NUM_EVT-1:0];
		end
	end

	// master enable and external edge choice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `AISRC_RST_CTRL;
		end else if (wr_hit(wr_take, paddr, `AISRC_OFF_CTRL)) begin
			ctrl_r <= pwdata[`AISRC_CTRL_W-1:0];
		end
	end

	// read mux; unknown offsets read zero
	always_comb begin
		rd_word = `AISRC_RST_DATA;
		unique case (paddr)
			`AISRC_OFF_STATUS: begin
				rd_word[`AISRC_NUM_EVT-1:0] = status_r;
			end
			`AISRC_OFF_ENABLE: begin
				rd_word[`AISRC_NUM_EVT-1:0] = enable_r;
			end
			`AISRC_OFF_CTRL: begin
				rd_word[`AISRC_CTRL_W-1:0] = ctrl_r;
			end
			`AISRC_OFF_PENDING: begin
				rd_word[`AISRC_NUM_EVT-1:0] = status_r & enable_r;
			end
			`AISRC_OFF_RAW: begin
				rd_word[`AISRC_RAW_ACQ_RUN]  = acq_in.acq_running_event;
				rd_word[`AISRC_RAW_OUT_RUN]  = out_in.out_running;
				rd_word[`AISRC_RAW_STOP_PIN] = pin_level[`AISRC_PIN_STOP];
				rd_word[`AISRC_RAW_EXT_PIN]  = pin_level[`AISRC_PIN_EXT];
			end
			default: begin
				rd_word = `AISRC_RST_DATA;
			end
		endcase
	end

	// answer one cycle after setup; read data captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `AISRC_RST_DATA;
		end else if (setup_ph) begin
			pready  <= 1'b1;
			pslverr <= !addr_ok;
			prdata  <= pwrite ? `AISRC_RST_DATA : rd_word;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// request low while an enabled flag pends and master enable is set;
	// registered, so it trails the flag by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !((|(status_r & enable_r)) &&
				ctrl_r[`AISRC_CTRL_MASTER_EN]);
		end
	end

endmodule

// *** bench/aisrc_monitor.sv ***
// concurrent checks on the ports of the interrupt source block
module aisrc_monitor (
	// clock and reset
	input wire logic                    pclk,
	input wire logic                    presetn,
	// apb side
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [11:0]             paddr,
	input wire logic [31:0]             pwdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic [31:0]             prdata,
	// event sources and pins
	input wire aisrc_pkg::aisrc_acq_type acq_in,
	input wire aisrc_pkg::aisrc_out_type out_in,
	input wire logic                    acq_stop_pin,
	input wire logic                    ext_irq_pin,
	// request line
	input wire logic                    irq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// the slave never stretches an access, so a missing answer is a hang
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer in the cycle after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	chk_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	chk_err_decode: assert property (pready |-> pslverr == !(paddr inside {12'h000,
		12'h004, 12'h008, 12'h00c, 12'h010}))
		else $error("error flag does not match the address map");
	chk_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
		else $error("read data not zero on a write");
	chk_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:13] == 19'h0)
		else $error("unused read bits not zero");
	// only software can withdraw a request: a write two edges earlier
	chk_irq_rise_write: assert property ($rose(irq_n) |-> $past(psel && penable && pwrite, 2))
		else $error("request dropped without a register write");
endmodule

bind aisrc_top aisrc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .acq_in(acq_in), .out_in(out_in),
	.acq_stop_pin(acq_stop_pin), .ext_irq_pin(ext_irq_pin), .irq_n(irq_n));

// *** bench/aisrc_host_model.sv ***
// host-side model that watches the active-low request line
module aisrc_host_model (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// request line and count of asserted cycles
	input  wire logic irq_n,
	output int        req_cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	// host reacts to the level only, so a count is all it keeps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_cycles <= 0;
		end else if (irq_n === 1'b0) begin
			req_cycles <= req_cycles + 1;
		end
	end
endmodule

// *** bench/acquisition_interrupt_sources_test.sv ***
// self-checking bench for the interrupt source block
`include "aisrc_regs.svh"
module acquisition_interrupt_sources_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, ev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [14:0] drv;
	int          err_total, total_checks, host_cnt;
	int          pos[13] = '{14, 1, 13, 12, 11, 9, 8, 7, 6, 5, 4, 2, 0};

	aisrc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .acq_in(drv[14:8]), .out_in(drv[7:2]),
		.acq_stop_pin(drv[1]), .ext_irq_pin(drv[0]), .irq_n(irq_n));
	aisrc_host_model host (.pclk(pclk), .presetn(presetn), .irq_n(irq_n),
		.req_cycles(host_cnt));

	// 40 MHz clock
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic close_out();
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; waits on pready since the master assumes no latency
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// no latency assumed; only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0000_0000);
		chk("prdata", rv, exp);
	endtask

	// request line is registered, so look at the second falling edge
	task automatic irq(input logic exp);
		repeat (2) @(negedge pclk);
		chk("irq_n", {31'h0, irq_n}, {31'h0, exp});
	endtask

	// pins need a few stable clocks, so every source is held four cycles
	task automatic fire(input int b);
		@(posedge pclk);
		drv[pos[b]] <= 1;
		repeat (4) @(posedge pclk);
		drv[pos[b]] <= 0;
		repeat (8) @(posedge pclk);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rd(12'(4 * i), 32'h0000_0000);
		end
		apb(1, `AISRC_OFF_RAW, 32'h0000_000f);
		rd(`AISRC_OFF_RAW, 32'h0000_0000);
		apb(1, 12'h014, 32'h0000_1fff);
		chk("pslverr", {31'h0, ev}, 32'h0000_0001);
		rd(12'h014, 32'h0000_0000);
		irq(1);
	endtask

	task automatic t_events();
		apb(1, `AISRC_OFF_ENABLE, 32'h0000_1fff);
		apb(1, `AISRC_OFF_CTRL, 32'h0000_0003);
		drv[10] <= 1;
		drv[3] <= 1;
		for (int b = 0; b < 13; b++) begin
			fire(b);
			rd(`AISRC_OFF_STATUS, 32'(1 << b));
			irq(0);
			apb(1, `AISRC_OFF_STATUS, 32'(1 << b));
			irq(1);
		end
	endtask

	task automatic t_gate();
		@(posedge pclk);
		drv[10] <= 0;
		drv[3] <= 0;
		fire(5);
		fire(6);
		fire(11);
		rd(`AISRC_OFF_STATUS, 32'h0000_0000);
		apb(1, `AISRC_OFF_CTRL, 32'h0000_0001);
		drv[0] <= 1;
		repeat (10) @(posedge pclk);
		rd(`AISRC_OFF_STATUS, 32'h0000_0000);
		drv[0] <= 0;
		repeat (10) @(posedge pclk);
		rd(`AISRC_OFF_STATUS, 32'h0000_1000);
		apb(1, `AISRC_OFF_STATUS, 32'h0000_1fff);
		apb(1, `AISRC_OFF_ENABLE, 32'h0000_0000);
		fire(2);
		rd(`AISRC_OFF_PENDING, 32'h0000_0000);
		irq(1);
		apb(1, `AISRC_OFF_ENABLE, 32'h0000_0004);
		rd(`AISRC_OFF_PENDING, 32'h0000_0004);
		irq(0);
		apb(1, `AISRC_OFF_CTRL, 32'h0000_0000);
		irq(1);
	endtask

	// control read-back, raw levels, then a reset in mid-run
	task automatic t_rerun();
		apb(1, `AISRC_OFF_CTRL, 32'h0000_0001);
		rd(`AISRC_OFF_CTRL, 32'h0000_0001);
		irq(0);
		drv <= 15'h4083;
		repeat (8) @(posedge pclk);
		rd(`AISRC_OFF_RAW, 32'h0000_000f);
		drv <= 15'h0000;
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		irq(1);
		rd(`AISRC_OFF_STATUS, 32'h0000_0000);
		rd(`AISRC_OFF_ENABLE, 32'h0000_0000);
		rd(`AISRC_OFF_CTRL, 32'h0000_0000);
	endtask

	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		drv = 15'h0000;
		err_total = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_events();
		t_gate();
		chk("host", {31'h0, host_cnt != 0}, 32'h0000_0001);
		t_rerun();
		close_out();
	end

	// the run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		close_out();
	end
endmodule
